// >>> logic/cps_pkg.sv
// Constants for the communication port selector.
// Assumes a 200 MHz system clock and an Avalon-MM register slave.
`default_nettype none
package cps_pkg;
   localparam int        CLK_HZ          = 200000000;
   localparam int        FLASH_MS        = 250;
   localparam int        FLASH_CYC       = (CLK_HZ / 1000) * FLASH_MS;
   localparam int        NET_HOLD_MS     = 50;
   localparam int        NET_HOLD_CYC    = (CLK_HZ / 1000) * NET_HOLD_MS;
   // Register word offsets (byte address = 4 * index)
   localparam logic [3:0] REG_CTRL       = 4'h0;
   localparam logic [3:0] REG_STATUS     = 4'h1;
   localparam logic [3:0] REG_ID         = 4'h2;
   // Control field positions
   localparam int        CTRL_HV         = 0;
   localparam int        CTRL_MEAS       = 1;
   localparam int        CTRL_RUN        = 2;
   localparam int        CTRL_UPLOAD     = 3;
   // Arbitrary identification value
   localparam logic [31:0] ID_VALUE      = 32'h0000C505;
   localparam logic [31:0] DEAD_VALUE    = 32'hDEADBEEF;
   localparam logic [3:0] MODE_LAST      = 4'h9;
   localparam logic [3:0] MODE_485_FIRST = 4'h6;
   localparam logic [3:0] ADDR_LOOP_CTRL = 4'h0;
   typedef enum logic [1:0]
   {
      CPS_PROTO_BIN8  = 2'b00,
      CPS_PROTO_ASCII = 2'b01,
      CPS_PROTO_BIN9  = 2'b10,
      CPS_PROTO_NONE  = 2'b11
   } cps_proto_t;
   typedef enum logic [2:0]
   {
      CPS_BAUD_115K0 = 3'b000,
      CPS_BAUD_115K2 = 3'b001,
      CPS_BAUD_57K6  = 3'b010,
      CPS_BAUD_19K2  = 3'b011,
      CPS_BAUD_10M   = 3'b100
   } cps_baud_t;
endpackage
`default_nettype wire

// >>> logic/cps_port_select.sv
// Communication port selector: plug sense, mode and address decode, LEDs.
// Assumes switch and plug-sense pins are asynchronous and Avalon-MM master on clk_in.
//
// Functional notes
// - Plug sensed: wired transceiver on, mode switch used
// - No plug: fiber-optic channel active
// - Exactly one interface active at once
// - Modes 0-2: binary RS-232 115/57.6/19.2
// - Modes 3-5: ASCII RS-232 115.2/57.6/19.2
// - Modes 6-7: binary RS-485 115/57.6
// - Modes 8-9: ASCII RS-485 115.2/57.6
// - RS-485 only with plug and modes 6-9
// - Address switch gives address; zero reserved
// - Supply LED follows supply enable
// - Wired LED while wired port active
// - Optical LED while fiber port active
// - Activity LED while measuring
// - Network LED on valid active traffic
// - Health LED steady running, flashing upload
// - Fiber channel uses nine-bit binary protocol
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module cps_port_select
   import cps_pkg::*;
(
   input  wire logic               clk_in,
   input  wire logic               arst_n_in,
   input  wire logic               plug_sense_in,
   input  wire logic [3:0]         mode_sw_in,
   input  wire logic [3:0]         addr_sw_in,
   input  wire logic               wired_valid_in,
   input  wire logic               fiber_valid_in,
   input  wire logic [3:0]         avs_address_in,
   input  wire logic               avs_read_in,
   input  wire logic               avs_write_in,
   input  wire logic [31:0]        avs_writedata_in,
   input  wire logic [3:0]         avs_byteenable_in,
   output logic [31:0]             avs_readdata_out,
   output logic                    avs_waitrequest_out,
   output logic                    wired_en_out,
   output logic                    rs485_en_out,
   output logic                    fiber_en_out,
   output cps_pkg::cps_proto_t     proto_out,
   output cps_pkg::cps_baud_t      baud_out,
   output logic                    mode_valid_out,
   output logic [3:0]              dev_addr_out,
   output logic                    addr_valid_out,
   output logic                    flush_wired_out,
   output logic                    flush_fiber_out,
   output logic                    supply_enabled_led_out,
   output logic                    wired_led_out,
   output logic                    optical_led_out,
   output logic                    activity_led_out,
   output logic                    network_led_out,
   output logic                    health_led_out
);
   ////////////////////////////////////////////////////////////////////////
   logic [2:0]  sync1_r;
   logic [2:0]  sync2_r;
   logic [3:0]  msync1_r;
   logic [3:0]  msync2_r;
   logic [3:0]  async1_r;
   logic [3:0]  async2_r;
   logic        plug_r;
   logic [3:0]  ctrl_r;
   logic        ack_r;
   logic [31:0] flash_cnt_r;
   logic [31:0] net_cnt_r;
   logic        plug_s;
   logic        wvalid_s;
   logic        fvalid_s;
   cps_proto_t  proto_nxt;
   cps_baud_t   baud_nxt;
   logic        m485_nxt;
   logic        mvalid_nxt;
   logic        req;

   assign plug_s   = sync2_r[0];
   assign wvalid_s = sync2_r[1];
   assign fvalid_s = sync2_r[2];
   assign req      = (avs_read_in | avs_write_in) & ~ack_r;

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for pins
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         sync1_r  <= 3'h0;
         sync2_r  <= 3'h0;
         msync1_r <= 4'h0;
         msync2_r <= 4'h0;
         async1_r <= 4'h0;
         async2_r <= 4'h0;
      end
      else
      begin
         sync1_r  <= {fiber_valid_in, wired_valid_in, plug_sense_in};
         sync2_r  <= sync1_r;
         msync1_r <= mode_sw_in;
         msync2_r <= msync1_r;
         async1_r <= addr_sw_in;
         async2_r <= async1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode switch decode
   always_comb
   begin
      proto_nxt  = CPS_PROTO_NONE;
      baud_nxt   = CPS_BAUD_115K0;
      m485_nxt   = 1'b0;
      mvalid_nxt = 1'b1;
      case (msync2_r)
         4'h0: begin proto_nxt = CPS_PROTO_BIN8;  baud_nxt = CPS_BAUD_115K0; end
         4'h1: begin proto_nxt = CPS_PROTO_BIN8;  baud_nxt = CPS_BAUD_57K6;  end
         4'h2: begin proto_nxt = CPS_PROTO_BIN8;  baud_nxt = CPS_BAUD_19K2;  end
         4'h3: begin proto_nxt = CPS_PROTO_ASCII; baud_nxt = CPS_BAUD_115K2; end
         4'h4: begin proto_nxt = CPS_PROTO_ASCII; baud_nxt = CPS_BAUD_57K6;  end
         4'h5: begin proto_nxt = CPS_PROTO_ASCII; baud_nxt = CPS_BAUD_19K2;  end
         4'h6: begin proto_nxt = CPS_PROTO_BIN8;  baud_nxt = CPS_BAUD_115K0; m485_nxt = 1'b1; end
         4'h7: begin proto_nxt = CPS_PROTO_BIN8;  baud_nxt = CPS_BAUD_57K6;  m485_nxt = 1'b1; end
         4'h8: begin proto_nxt = CPS_PROTO_ASCII; baud_nxt = CPS_BAUD_115K2; m485_nxt = 1'b1; end
         4'h9: begin proto_nxt = CPS_PROTO_ASCII; baud_nxt = CPS_BAUD_57K6;  m485_nxt = 1'b1; end
         default: mvalid_nxt = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Port selection and protocol outputs
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         plug_r         <= 1'b0;
         wired_en_out   <= 1'b0;
         rs485_en_out   <= 1'b0;
         fiber_en_out   <= 1'b1;
         proto_out      <= CPS_PROTO_BIN9;
         baud_out       <= CPS_BAUD_10M;
         mode_valid_out <= 1'b1;
      end
      else
      begin
         plug_r <= plug_s;
         wired_en_out <= plug_s;
         fiber_en_out <= ~plug_s;
         rs485_en_out <= plug_s & m485_nxt;
         if (plug_s)
         begin
            proto_out      <= proto_nxt;
            baud_out       <= baud_nxt;
            mode_valid_out <= mvalid_nxt;
         end
         else
         begin
            proto_out      <= CPS_PROTO_BIN9;
            baud_out       <= CPS_BAUD_10M;
            mode_valid_out <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flush pulse on plug change
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         flush_wired_out <= 1'b0;
         flush_fiber_out <= 1'b0;
      end
      else
      begin
         flush_wired_out <= plug_r & ~plug_s;
         flush_fiber_out <= ~plug_r & plug_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // device address decode
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         dev_addr_out   <= 4'h0;
         addr_valid_out <= 1'b0;
      end
      else
      begin
         dev_addr_out   <= async2_r;
         addr_valid_out <= (async2_r != ADDR_LOOP_CTRL);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave, one wait cycle per access
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ack_r               <= 1'b0;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h00000000;
         ctrl_r              <= 4'h0;
      end
      else
      begin
         ack_r               <= req;
         avs_waitrequest_out <= ~req;
         if (avs_write_in && !avs_waitrequest_out && avs_address_in == REG_CTRL && avs_byteenable_in[0])
         begin
            ctrl_r <= avs_writedata_in[3:0];
         end
         if (req && avs_read_in)
         begin
            if (avs_address_in == REG_CTRL)
            begin
               avs_readdata_out <= {28'h0000000, ctrl_r};
            end
            else if (avs_address_in == REG_STATUS)
            begin
               avs_readdata_out <= {16'h0000, async2_r, msync2_r, 2'h0, proto_out,
                                    plug_s, rs485_en_out, fiber_en_out, wired_en_out};
            end
            else if (avs_address_in == REG_ID)
            begin
               avs_readdata_out <= ID_VALUE;
            end
            else
            begin
               avs_readdata_out <= DEAD_VALUE;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Health flash and network hold timers
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         flash_cnt_r <= 32'h00000000;
         net_cnt_r   <= 32'h00000000;
      end
      else
      begin
         flash_cnt_r <= (flash_cnt_r >= 32'(FLASH_CYC - 1)) ? 32'h00000000 : flash_cnt_r + 32'h00000001;
         if ((plug_s && wvalid_s) || (!plug_s && fvalid_s))
         begin
            net_cnt_r <= 32'(NET_HOLD_CYC);
         end
         else if (net_cnt_r != 32'h00000000)
         begin
            net_cnt_r <= net_cnt_r - 32'h00000001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Indicator LEDs
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         supply_enabled_led_out <= 1'b0;
         wired_led_out          <= 1'b0;
         optical_led_out        <= 1'b1; // Fiber is active in reset
         activity_led_out       <= 1'b0;
         network_led_out        <= 1'b0;
         health_led_out         <= 1'b0;
      end
      else
      begin
         supply_enabled_led_out <= ctrl_r[CTRL_HV];
         wired_led_out          <= plug_s;
         optical_led_out        <= ~plug_s;
         activity_led_out       <= ctrl_r[CTRL_MEAS];
         network_led_out        <= (net_cnt_r != 32'h00000000);
         if (ctrl_r[CTRL_UPLOAD])
         begin
            if (flash_cnt_r == 32'h00000000)
            begin
               health_led_out <= ~health_led_out;
            end
         end
         else
         begin
            health_led_out <= ctrl_r[CTRL_RUN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // exactly one port
   property p_one_port;
      @(posedge clk_in) disable iff (!arst_n_in) wired_en_out != fiber_en_out;
   endproperty
   a_one_port: assert property (p_one_port) else $error("both or no ports active");
   // plug selects wired on the next cycle
   property p_plug_wired;
      @(posedge clk_in) disable iff (!arst_n_in) plug_s |=> wired_en_out;
   endproperty
   a_plug_wired: assert property (p_plug_wired) else $error("wired not enabled");
   property p_fiber;
      @(posedge clk_in) disable iff (!arst_n_in) !plug_s |=> fiber_en_out && proto_out == CPS_PROTO_BIN9;
   endproperty
   a_fiber: assert property (p_fiber) else $error("fiber not active");
   // RS-485 needs plug and mode 6-9
   property p_485;
      @(posedge clk_in) disable iff (!arst_n_in)
         rs485_en_out |-> $past(plug_s) && $past(msync2_r) >= MODE_485_FIRST && $past(msync2_r) <= MODE_LAST;
   endproperty
   a_485: assert property (p_485) else $error("rs485 enabled wrongly");
   property p_mode2;
      @(posedge clk_in) disable iff (!arst_n_in)
         plug_s && msync2_r == 4'h2 |=> proto_out == CPS_PROTO_BIN8 && baud_out == CPS_BAUD_19K2;
   endproperty
   a_mode2: assert property (p_mode2) else $error("mode 2 decode wrong");
   // mode 8 gives ASCII 115.2 on RS-485
   property p_mode8;
      @(posedge clk_in) disable iff (!arst_n_in)
         plug_s && msync2_r == 4'h8 |=> proto_out == CPS_PROTO_ASCII && baud_out == CPS_BAUD_115K2 && rs485_en_out;
   endproperty
   a_mode8: assert property (p_mode8) else $error("mode 8 decode wrong");
   property p_addr;
      @(posedge clk_in) disable iff (!arst_n_in) addr_valid_out |-> dev_addr_out != ADDR_LOOP_CTRL;
   endproperty
   a_addr: assert property (p_addr) else $error("reserved address valid");
   property p_flush;
      @(posedge clk_in) disable iff (!arst_n_in) $fell(plug_s) |=> flush_wired_out ##1 !flush_wired_out;
   endproperty
   a_flush: assert property (p_flush) else $error("flush pulse wrong");
   property p_optled;
      @(posedge clk_in) disable iff (!arst_n_in) optical_led_out == fiber_en_out;
   endproperty
   a_optled: assert property (p_optled) else $error("optical led mismatch");

   c_plug_in:  cover property (@(posedge clk_in) disable iff (!arst_n_in) $rose(wired_en_out));
   c_plug_out: cover property (@(posedge clk_in) disable iff (!arst_n_in) $rose(fiber_en_out));
   c_rs485:    cover property (@(posedge clk_in) disable iff (!arst_n_in) $rose(rs485_en_out));
   c_flash:    cover property (@(posedge clk_in) disable iff (!arst_n_in) ctrl_r[CTRL_UPLOAD] && $changed(health_led_out));
endmodule
`default_nettype wire

// >>> sim/cps_link_partner.sv
// Far-side link partner: host or loop controller sending traffic.
// Assumes the selector's port enables; bench decides when to talk.
`timescale 1ns/100ps
`default_nettype none
module cps_link_partner
(
   input  wire logic clk_in,
   input  wire logic talk_in,
   input  wire logic stray_in,
   input  wire logic wired_en_in,
   input  wire logic fiber_en_in,
   output var logic  wired_valid_out,
   output var logic  fiber_valid_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Traffic on the enabled port; stray talks on the idle one
   always_ff @(posedge clk_in)
   begin
      wired_valid_out <= talk_in && (stray_in ? !wired_en_in : wired_en_in);
      fiber_valid_out <= talk_in && (stray_in ? !fiber_en_in : fiber_en_in);
   end
endmodule
`default_nettype wire

// >>> sim/cps_port_select_bench.sv
// Self-checking bench for the port selector: pins, LEDs, registers.
// Assumes a link partner model and an Avalon-MM master built here.
`timescale 1ns/100ps
`default_nettype none
module cps_port_select_bench;
   import cps_pkg::*;
   logic        clk_in            = 1'b0;
   logic        arst_n_in         = 1'b0;
   logic        plug_sense_in     = 1'b1;
   logic [3:0]  mode_sw_in        = 4'h0;
   logic [3:0]  addr_sw_in        = 4'h1;
   logic        talk              = 1'b0;
   logic        stray             = 1'b0;
   logic [3:0]  avs_address_in    = 4'h0;
   logic        avs_read_in       = 1'b0;
   logic        avs_write_in      = 1'b0;
   logic [31:0] avs_writedata_in  = 32'h0;
   logic [3:0]  avs_byteenable_in = 4'h0;
   logic [31:0] avs_readdata_out, rd, rnd;
   logic        wired_valid, fiber_valid, avs_waitrequest_out, wired_en_out, rs485_en_out, fiber_en_out;
   logic        mode_valid_out, addr_valid_out, flush_wired_out, flush_fiber_out, supply_enabled_led_out;
   logic        wired_led_out, optical_led_out, activity_led_out, network_led_out, health_led_out;
   cps_proto_t  proto_out;
   cps_baud_t   baud_out;
   logic [3:0]  dev_addr_out;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          seed      = 65226;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and instances
   always #2.5 clk_in = ~clk_in;
   cps_link_partner cps_link_partner_inst (.clk_in, .talk_in(talk), .stray_in(stray), .wired_en_in(wired_en_out),
      .fiber_en_in(fiber_en_out), .wired_valid_out(wired_valid), .fiber_valid_out(fiber_valid));
   cps_port_select cps_port_select_inst (.clk_in, .arst_n_in, .plug_sense_in, .mode_sw_in, .addr_sw_in,
      .wired_valid_in(wired_valid), .fiber_valid_in(fiber_valid), .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .wired_en_out,
      .rs485_en_out, .fiber_en_out, .proto_out, .baud_out, .mode_valid_out, .dev_addr_out, .addr_valid_out,
      .flush_wired_out, .flush_fiber_out, .supply_enabled_led_out, .wired_led_out, .optical_led_out,
      .activity_led_out, .network_led_out, .health_led_out);

   ////////////////////////////////////////////////////////////////////////////
   // Compare, expectation and closing helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic cps_proto_t exp_proto(input logic p, input logic [3:0] m);
      if (!p)
         return CPS_PROTO_BIN9;
      if (m > MODE_LAST)
         return CPS_PROTO_NONE;
      return (m inside {4'h3, 4'h4, 4'h5, 4'h8, 4'h9}) ? CPS_PROTO_ASCII : CPS_PROTO_BIN8;
   endfunction
   function automatic cps_baud_t exp_baud(input logic p, input logic [3:0] m);
      if (!p)
         return CPS_BAUD_10M;
      case (m)
         4'h0, 4'h6: return CPS_BAUD_115K0;
         4'h3, 4'h8: return CPS_BAUD_115K2;
         4'h2, 4'h5: return CPS_BAUD_19K2;
         default:    return CPS_BAUD_57K6;
      endcase
   endfunction
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM master: hold request until waitrequest sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_in);
      avs_read_in       <= !wr;
      avs_write_in      <= wr;
      avs_address_in    <= a;
      avs_writedata_in  <= d;
      avs_byteenable_in <= be;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (avs_waitrequest_out !== 1'b0 && n < 50);
      q = avs_readdata_out;
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
      chk(n < 50, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Apply pins, let them settle, check every decoded output except baud for an invalid plugged mode, and STATUS
   task automatic set_pins(input logic p, input logic [3:0] m, input logic [3:0] a);
      logic r4;
      @(posedge clk_in);
      plug_sense_in <= p;
      mode_sw_in    <= m;
      addr_sw_in    <= a;
      repeat (4) @(posedge clk_in);
      #1;
      r4 = p && m >= MODE_485_FIRST && m <= MODE_LAST;
      chk(wired_en_out, p);
      chk(fiber_en_out, !p);
      chk(wired_en_out ^ fiber_en_out, 1'b1);
      chk(proto_out, exp_proto(p, m));
      if (!p || m <= MODE_LAST)
         chk(baud_out, exp_baud(p, m));
      chk(mode_valid_out, !p || m <= MODE_LAST);
      chk(rs485_en_out, r4);
      chk(dev_addr_out, a);
      chk(addr_valid_out, a != ADDR_LOOP_CTRL);
      chk(wired_led_out, p);
      chk(optical_led_out, !p);
      bus(1'b0, REG_STATUS, 32'h0, 4'hF, rd);
      chk(rd, {16'h0, a, m, 2'b00, exp_proto(p, m), p, r4, !p, p});
   endtask

   // Change plug only and count flush pulses over the switch
   task automatic flip(input logic p, input int ew, input int ef);
      int nw;
      int nf;
      nw = 0;
      nf = 0;
      @(posedge clk_in);
      plug_sense_in <= p;
      repeat (6)
      begin
         @(posedge clk_in);
         #1;
         nw += flush_wired_out;
         nf += flush_fiber_out;
      end
      chk(nw, ew);
      chk(nf, ef);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk_in);
      #1;
      chk({fiber_en_out, wired_en_out, proto_out, baud_out, avs_waitrequest_out}, {2'b10, CPS_PROTO_BIN9,
          CPS_BAUD_10M, 1'b1});
      @(posedge clk_in);
      arst_n_in <= 1'b1;
      set_pins(1'b1, 4'h0, 4'h1);
      // Traffic on the idle port must not light the network LED
      talk  <= 1'b1;
      stray <= 1'b1;
      repeat (8) @(posedge clk_in);
      #1;
      chk(network_led_out, 1'b0);
      stray <= 1'b0;
      repeat (8) @(posedge clk_in);
      #1;
      chk(network_led_out, 1'b1);
      // Second reset in mid-run clears the stretched LED
      @(posedge clk_in);
      talk      <= 1'b0;
      arst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
      chk({network_led_out, fiber_en_out, optical_led_out}, 3'b011);
      @(posedge clk_in);
      arst_n_in <= 1'b1;
      // sweep all sixteen mode and address switch settings with the plug in
      for (int i = 0; i < 16; i++)
         set_pins(1'b1, i[3:0], i[3:0]);
      flip(1'b0, 1, 0);
      set_pins(1'b0, 4'h7, 4'hF);
      flip(1'b1, 0, 1);
      for (int i = 0; i < 24; i++)
      begin
         rnd = $random(seed);
         set_pins(rnd[0], rnd[7:4], rnd[11:8]);
      end
      // Control register, LEDs, refused and unmapped accesses
      bus(1'b1, REG_CTRL, 32'h5, 4'h1, rd);
      repeat (3) @(posedge clk_in);
      #1;
      chk({supply_enabled_led_out, activity_led_out, health_led_out}, 3'b101);
      bus(1'b1, REG_CTRL, 32'hA, 4'hE, rd);
      bus(1'b0, REG_CTRL, 32'h0, 4'hF, rd);
      chk(rd, 32'h5);
      bus(1'b1, REG_CTRL, 32'hFFFFFFF2, 4'hF, rd);
      bus(1'b0, REG_CTRL, 32'h0, 4'hF, rd);
      chk(rd, 32'h2);
      repeat (3) @(posedge clk_in);
      #1;
      chk({supply_enabled_led_out, activity_led_out, health_led_out}, 3'b010);
      // Upload overrides the steady running level; the LED keeps its last level until the flash count wraps
      bus(1'b1, REG_CTRL, 32'hC, 4'h1, rd);
      repeat (3) @(posedge clk_in);
      #1;
      chk(health_led_out, 1'b0);
      bus(1'b0, REG_ID, 32'h0, 4'hF, rd);
      chk(rd, ID_VALUE);
      bus(1'b1, 4'h3, 32'h1, 4'hF, rd);
      bus(1'b0, 4'h3, 32'h0, 4'hF, rd);
      chk(rd, DEAD_VALUE);
      report_and_stop();
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      #100000;
      bad_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
